// ---- bench/port_pin_model.sv ----
// port latch, direction bit and pad of one compare output pin
// assumes the bench sets latch and direction on its inputs
`timescale 1ns/100ps
module port_pin_model (
  input  wire logic i_core_clk,
  input  wire logic i_set_data,
  input  wire logic i_set_dir,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  output logic      o_port_data = 1'b0,
  output logic      o_direction = 1'b0,
  output logic      o_pad
);
  // latch and direction registers, loaded each clock
  always @(posedge i_core_clk) begin
    o_port_data <= i_set_data;
    o_direction <= i_set_dir;
  end
  // pad shows the pull-up while the pin is not driven
  assign o_pad = i_pin_oe_n ? 1'b1 : i_pin_out;
endmodule

// ---- bench/test_timer_compare_waveform.sv ----
// self-checking bench for the timer waveform block
// assumes package, design, checker and pin model compiled first
`timescale 1ns/100ps
module test_timer_compare_waveform;
  import tc_wave_pkg::*;
  `define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
    errors++; $display("wrong value at %0t: %s", $time, m); end end
  // ----
  // stimulus, reference model and checks
  // ----
  logic       clk = 0, rstn = 0, tick = 0, cwr = 0, awr = 0, fa = 0, fb = 0;
  logic       oclr = 0, aclr = 0, bclr = 0, sa = 0, da = 0, sb = 0, db = 0;
  logic [3:0] mode = 0;
  logic [3:0] fm [5] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  action_t    act = 0, actb = 0;
  count_t     wdat = 0, cap = 0, cnt, cmpa, cmpb;
  logic       ovf, fla, sta, pa, pan, pb, pbn, pda, dra, pada, pdb, drb;
  logic       flb, fcap, stb;
  int         errors = 0, comparisons = 0, seed = 32'h181b;
  int         m_cnt, m_cmp, m_buf, m_t;
  bit         m_ovf, m_fla, m_st, m_blk, hit, pwm, m_flb, m_cap, m_stb;
  always #10 clk = ~clk;
  timer_compare_waveform timer_compare_waveform_i (
    .i_core_clk(clk), .i_resetn(rstn), .i_tick(tick),
    .i_waveform_mode_field(mode), .i_chan_a_output_action(act),
    .i_chan_b_output_action(actb), .i_count_wr(cwr), .i_count_wdata(wdat),
    .i_cmp_a_wr(awr), .i_cmp_b_wr(awr), .i_cmp_wdata(wdat),
    .i_capture_reg(cap), .i_force_a(fa), .i_force_b(fb), .i_ovf_clr(oclr),
    .i_flag_a_clr(aclr), .i_flag_b_clr(bclr), .i_port_data_a(pda),
    .i_port_data_b(pdb), .i_chan_a_pin_direction(dra),
    .i_chan_b_pin_direction(drb), .o_count_value(cnt),
    .o_compare_reg_a(cmpa), .o_compare_reg_b(cmpb), .o_overflow_flag(ovf),
    .o_compare_flag_a(fla), .o_compare_flag_b(flb),
    .o_capture_top_flag(fcap), .o_chan_a_output_state(sta),
    .o_chan_b_output_state(stb),
    .o_pin_a_out(pa), .o_pin_a_oe_n(pan), .o_pin_b_out(pb),
    .o_pin_b_oe_n(pbn));
  port_pin_model port_pin_model_i (.i_core_clk(clk), .i_set_data(sa),
    .i_set_dir(da), .i_pin_out(pa), .i_pin_oe_n(pan), .o_port_data(pda),
    .o_direction(dra), .o_pad(pada));
  port_pin_model port_pin_model_b_i (.i_core_clk(clk), .i_set_data(sb),
    .i_set_dir(db), .i_pin_out(pb), .i_pin_oe_n(pbn), .o_port_data(pdb),
    .o_direction(drb), .o_pad());
  // next output state for a match or a force
  function automatic bit apply(action_t a, bit s);
    return a[1] ? a[0] : s ^ a[0];
  endfunction
  // reference model, stepped on the same edge as the design
  always @(posedge clk) begin
    pwm = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    m_t = mode == 4 || mode == 15 ? m_cmp : mode == 12 || mode == 14 ? cap
        : mode == 5 ? 16'h00FF : mode == 6 ? 16'h01FF
        : mode == 7 ? 16'h03FF : 16'hFFFF;
    hit = tick && !cwr && !m_blk && m_cnt == m_cmp;
    if (!rstn) begin
      {m_cnt, m_cmp, m_buf} = '0;
      {m_ovf, m_fla, m_st, m_blk, m_flb, m_cap, m_stb} = 7'h00;
    end else begin
      if (oclr) m_ovf = 0;
      if (aclr) {m_fla, m_cap} = 2'b00;
      if (bclr) m_flb = 0;
      if (hit) begin
        {m_fla, m_flb} = 2'b11;
        m_st  = apply(act, m_st);
        m_stb = apply(actb, m_stb);
      end else if (pwm && tick && !cwr && m_cnt == m_t) begin
        if (act[1]) m_st = !act[0];
        if (actb[1]) m_stb = !actb[0];
      end
      if (fa && !pwm) m_st = apply(act, m_st);
      if (fb && !pwm) m_stb = apply(actb, m_stb);
      if (cwr) begin
        m_cnt = wdat;
        m_blk = 1;
      end else if (tick) begin
        m_blk = 0;
        if ((pwm || mode == 4 || mode == 12) && m_cnt == m_t) begin
          m_cnt = 0;
          if (pwm) m_ovf = 1;
          if (pwm) m_cmp = m_buf;
          if (mode == 12 || mode == 14) m_cap = 1;
        end else begin
          m_ovf = m_ovf | (m_cnt == 16'hFFFF);
          m_cnt = (m_cnt + 1) & 16'hFFFF;
        end
      end
      if (awr) m_buf = wdat;
      if (awr && !pwm) m_cmp = wdat;
    end
  end
  // compare design and model each cycle, before new inputs land
  always @(negedge clk) begin
    `CHK(cnt, count_t'(m_cnt), "count")
    `CHK(cmpa, count_t'(m_cmp), "compare a")
    `CHK(ovf, m_ovf, "overflow flag")
    `CHK(fla, m_fla, "compare flag a")
    `CHK(sta, m_st, "output state a")
    `CHK(pa, act != 0 ? m_st : pda, "pin value a")
    `CHK(pada, dra ? (act != 0 ? m_st : pda) : 1'b1, "pad a")
    `CHK(cmpb, count_t'(m_cmp), "compare b")
    `CHK(flb, m_flb, "compare flag b")
    `CHK(fcap, m_cap, "capture top flag")
    `CHK(stb, m_stb, "output state b")
    `CHK(pb, actb != 0 ? m_stb : pdb, "pin value b")
    `CHK(pbn, !drb, "pin enable b")
  end
  task automatic run(input int n, input bit rnd);
    logic [31:0] r;
    repeat (n) begin
      @(negedge clk);
      r = $random(seed);
      tick <= rnd ? r[0] : 1'b1;
      fa   <= rnd && !r[0] && r[5:2] == 0 && !pwm;
      fb   <= rnd && !r[0] && r[9:6] == 0 && !pwm;
      {sa, da, sb, db} <= r[13:10];
      oclr <= r[17:14] == 0;
      aclr <= r[21:18] == 0;
      bclr <= r[22];
      if (rnd && r[26:23] == 0) act <= r[28:27];
      actb <= r[30:29];
      cwr  <= 1'b0;
      awr  <= 1'b0;
    end
  endtask
  task automatic put(input bit c, input count_t v);
    @(negedge clk);
    {tick, fa, fb} <= 3'h0;
    cwr  <= c;
    awr  <= !c;
    wdat <= v;
  endtask
  task automatic start(input logic [3:0] md, input action_t a, count_t c);
    @(negedge clk);
    rstn <= 1'b0;
    mode <= md;
    act  <= a;
    cap  <= 16'h0100;
    repeat (2) @(negedge clk);
    rstn <= 1'b1;
    put(1'b0, c);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    start(4'h0, 2'h1, 16'h0010);
    put(1'b1, 16'hFFF8);
    run(40, 1'b1);
    put(1'b1, 16'h0010); // count equal to compare: match held off
    run(300, 1'b1);
    $display("test normal mode done");
    start(4'h4, 2'h1, 16'h0000);
    run(20, 1'b0);
    start(4'h4, 2'h1, 16'h0003);
    run(3, 1'b0);
    put(1'b0, 16'h0001); // top below count: wraps through zero
    run(65540, 1'b0);
    $display("test clear on compare done");
    start(4'hC, 2'h3, 16'h0000);
    run(800, 1'b1);
    $display("test capture top done");
    foreach (fm[i]) begin
      start(fm[i], 2'h2, 16'h0050);
      run(2200, 1'b1);
      $display("test fast pwm mode %0d done", fm[i]);
    end
    give_verdict();
  end
  // watchdog sized above the expected run length
  initial begin
    #(90000 * 20);
    errors++;
    give_verdict();
  end
endmodule

// ---- bench/timer_compare_waveform_properties.sv ----
// assertions on the ports of the timer waveform block
// assumes tc_wave_pkg is compiled first; bound to the top module
`timescale 1ns/100ps
module timer_compare_waveform_properties
  import tc_wave_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic       i_tick,
  input wire logic [3:0] i_waveform_mode_field,
  input wire action_t    i_chan_a_output_action,
  input wire logic       i_count_wr,
  input wire count_t     i_count_wdata,
  input wire logic       i_force_a,
  input wire logic       i_port_data_a,
  input wire logic       i_chan_a_pin_direction,
  input wire count_t     o_count_value,
  input wire count_t     o_compare_reg_a,
  input wire logic       o_overflow_flag,
  input wire logic       o_compare_flag_a,
  input wire logic       o_chan_a_output_state,
  input wire logic       o_pin_a_out,
  input wire logic       o_pin_a_oe_n
);
  // ----
  // helper logic
  // ----
  logic       blk_q;
  logic       blk_d;
  logic [3:0] md;
  logic       adv;
  logic       hit;
  // advancing tick and an unblocked channel a match
  assign md  = i_waveform_mode_field;
  assign adv = i_tick && !i_count_wr;
  assign hit = adv && !blk_q && o_count_value == o_compare_reg_a;
  // match block window opened by a counter write
  always_comb begin
    blk_d = i_count_wr || (blk_q && !i_tick);
  end
  always_ff @(posedge i_core_clk) begin
    blk_q <= i_resetn && blk_d;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // ----
  // properties
  // ----
  a_reset_state: assert property (disable iff (1'b0)
    !i_resetn |=> !o_chan_a_output_state) else $error("state not cleared");
  a_pin_source: assert property (
    o_pin_a_out == (i_chan_a_output_action != 2'h0 ? o_chan_a_output_state
    : i_port_data_a)) else $error("pin source wrong");
  a_pin_enable: assert property (
    o_pin_a_oe_n == !i_chan_a_pin_direction) else $error("pin enable wrong");
  a_idle_hold: assert property (
    !i_tick && !i_count_wr |=> $stable(o_count_value))
    else $error("count moved");
  a_normal_wrap: assert property (
    md == 4'h0 && adv && o_count_value == 16'hFFFF |=>
    o_count_value == 16'h0000 && o_overflow_flag) else $error("no wrap");
  a_count_write: assert property (
    i_count_wr |=> o_count_value == $past(i_count_wdata))
    else $error("write lost");
  a_ctc_clear: assert property (
    md == 4'h4 && hit |=> o_count_value == 16'h0000 && o_compare_flag_a)
    else $error("no clear on match");
  a_no_action: assert property (
    i_chan_a_output_action == 2'h0 |=> $stable(o_chan_a_output_state))
    else $error("state moved");
  a_force_toggle: assert property (
    md == 4'h0 && i_force_a && !i_tick && i_chan_a_output_action == 2'h1
    |=> o_chan_a_output_state != $past(o_chan_a_output_state))
    else $error("force ignored");
  a_fpwm_top: assert property (
    md == 4'h5 && adv && o_count_value == 16'h00FF |=>
    o_count_value == 16'h0000 && o_overflow_flag) else $error("no top");
  a_fpwm_match: assert property (
    md == 4'h5 && hit && i_chan_a_output_action == 2'h2
    |=> !o_chan_a_output_state && o_compare_flag_a) else $error("no match");
  a_match_block: assert property (
    blk_q && adv && !o_compare_flag_a |=> !o_compare_flag_a)
    else $error("match not blocked");
  c_ctc_top: cover property (md == 4'h4 && hit);
  c_wrap: cover property (md == 4'h0 && adv && o_count_value == 16'hFFFF);
  c_block: cover property (blk_q && adv);
endmodule

bind timer_compare_waveform timer_compare_waveform_properties
  timer_compare_waveform_properties_i (.i_core_clk, .i_resetn, .i_tick,
  .i_waveform_mode_field, .i_chan_a_output_action, .i_count_wr,
  .i_count_wdata, .i_force_a, .i_port_data_a, .i_chan_a_pin_direction,
  .o_count_value, .o_compare_reg_a, .o_overflow_flag, .o_compare_flag_a,
  .o_chan_a_output_state, .o_pin_a_out, .o_pin_a_oe_n);

// ---- logic/compare_output_unit.sv ----
// one compare output channel: output state register and pin override
// assumes match, bottom and force events come from the timer core
`timescale 1ns/100ps
`include "tc_wave_consts.svh"
module compare_output_unit
  import tc_wave_pkg::*;
(
  input  wire logic    i_core_clk,
  input  wire logic    i_resetn,
  input  wire logic    i_tick,          // timer clock enable
  input  wire logic    i_is_pwm,
  input  wire action_t i_action,        // output_action_field
  input  wire logic    i_match,         // compare match, already gated
  input  wire logic    i_bottom,        // counter cleared from top
  input  wire logic    i_force,         // force_compare_strobe
  input  wire logic    i_port_data,
  input  wire logic    i_pin_direction, // pin_direction_bit
  output logic         o_state,         // compare_output_state
  output logic         o_pin_out,
  output logic         o_pin_oe_n       // low while pin is driven
);
  logic state_q;
  logic state_d;

  // ----------------------------------------------------------------
  // non-pwm action on a value
  // ----------------------------------------------------------------
  function automatic logic apply_act(input action_t a, input logic s);
    case (a)
      `ACT_TOGGLE: apply_act = ~s;
      `ACT_CLEAR:  apply_act = 1'b0;
      `ACT_SET:    apply_act = 1'b1;
      default:     apply_act = s;
    endcase
  endfunction

  // next output state; action field read live so a new value acts
  // on the first match after it is written
  always_comb begin
    state_d = state_q;
    if (!i_is_pwm) begin
      if (i_force)
        state_d = apply_act(i_action, state_q);
      else if (i_tick && i_match)
        state_d = apply_act(i_action, state_q);  // zero
    end else if (i_tick) begin
      case (i_action)
        `ACT_CLEAR: begin                        // non-inverting
          if (i_match)
            state_d = 1'b0;
          else if (i_bottom)
            state_d = 1'b1;
        end
        `ACT_SET: begin                          // inverting
          if (i_match)
            state_d = 1'b1;
          else if (i_bottom)
            state_d = 1'b0;
        end
        `ACT_TOGGLE: begin
          if (i_match)
            state_d = ~state_q;
        end
        default: state_d = state_q;
      endcase
    end
  end

  // state register, cleared by reset regardless of pin level
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn)
      state_q <= `OC_RESET;
    else
      state_q <= state_d;
  end

  // port override: value source from action, direction from port
  assign o_state    = state_q;
  assign o_pin_out  = (i_action != `ACT_NONE) ? state_q : i_port_data;
  assign o_pin_oe_n = ~i_pin_direction;
endmodule

// ---- logic/tc_wave_consts.svh ----
// constants for the timer waveform block: modes, tops, actions
// assumes inclusion by bare name from the package and modules
`ifndef TC_WAVE_CONSTS_SVH
`define TC_WAVE_CONSTS_SVH
`define CNT_W          16
`define CNT_MAX        16'hFFFF
`define CNT_BOTTOM     16'h0000
`define TOP_8BIT       16'h00FF
`define TOP_9BIT       16'h01FF
`define TOP_10BIT      16'h03FF
`define OC_RESET       1'b0
`define CNT_RESET      16'h0000
`define WGM_NORMAL     4'h0
`define WGM_CTC_A      4'h4
`define WGM_FPWM_8     4'h5
`define WGM_FPWM_9     4'h6
`define WGM_FPWM_10    4'h7
`define WGM_CTC_CAP    4'hC
`define WGM_FPWM_CAP   4'hE
`define WGM_FPWM_A     4'hF
`define ACT_NONE       2'h0
`define ACT_TOGGLE     2'h1
`define ACT_CLEAR      2'h2
`define ACT_SET        2'h3
`endif

// ---- logic/tc_wave_pkg.sv ----
// types shared by the timer waveform block
// assumes the constants header sits in the include path
`include "tc_wave_consts.svh"
package tc_wave_pkg;
  typedef logic [`CNT_W-1:0] count_t;
  typedef logic [1:0]        action_t;
  // counting class derived from the mode field
  typedef enum logic [1:0] {
    SEQ_NORMAL = 2'b00,
    SEQ_CTC    = 2'b01,
    SEQ_FPWM   = 2'b11,
    SEQ_OTHER  = 2'b10
  } seq_class_t;
endpackage

// ---- logic/timer_compare_waveform.sv ----
// timer waveform generation: counter sequence, flags, two channels
// assumes a prescaler tick on i_tick and software strobes of one cycle
// assumes count, compare and capture inputs come from the same clock
// Contract
// - reset clears each compare output state to zero
// - nonzero action field makes output state drive pin value
// - output state reaches pin only while direction is output
// - action field never affects input capture
// - action zero leaves output state unchanged on match
// - new action value acts from first match after write
// - force strobe applies action immediately in non-pwm modes
// - mode field sets counting; action sets output behaviour
// - mode 0 counts up and wraps from max to zero
// - normal mode sets overflow flag when counter becomes zero
// - overflow flag clears when its interrupt is serviced
// - normal mode accepts counter writes at any time
// - modes 4 and 12 clear counter on match with top register
// - ctc top written directly; below count wraps through zero
// - ctc top reached signalled on compare a or capture flag
// - ctc toggle on channel a gives half clock at zero; in mode 12 only when the capture top is zero too
// - ctc sets overflow flag when counter passes max to zero
// - modes 5,6,7,14,15 are single slope fast pwm
// - fast pwm non-inverting clears on match, sets at bottom
// - fast pwm top per mode; counter clears cycle after top
// - fast pwm sets channel compare flag on each match
// - compare registers buffered in pwm, updated at top
// - fast pwm sets overflow flag at top with top flag
// - counter write blocks matches in the next timer cycle
`timescale 1ns/100ps
`include "tc_wave_consts.svh"
module timer_compare_waveform
  import tc_wave_pkg::*;
(
  input  wire logic    i_core_clk,
  input  wire logic    i_resetn,
  input  wire logic    i_tick,          // prescaler timer clock enable
  input  wire logic [3:0] i_waveform_mode_field,
  input  wire action_t i_chan_a_output_action,
  input  wire action_t i_chan_b_output_action,
  input  wire logic    i_count_wr,      // software write of count_value
  input  wire count_t  i_count_wdata,
  input  wire logic    i_cmp_a_wr,      // write compare_reg_a
  input  wire logic    i_cmp_b_wr,
  input  wire count_t  i_cmp_wdata,
  input  wire count_t  i_capture_reg,   // from capture unit, unbuffered
  input  wire logic    i_force_a,       // force_compare_strobe a
  input  wire logic    i_force_b,
  input  wire logic    i_ovf_clr,       // overflow serviced or w1c
  input  wire logic    i_flag_a_clr,
  input  wire logic    i_flag_b_clr,
  input  wire logic    i_port_data_a,
  input  wire logic    i_port_data_b,
  input  wire logic    i_chan_a_pin_direction,
  input  wire logic    i_chan_b_pin_direction,
  output count_t       o_count_value,
  output count_t       o_compare_reg_a,  // active compare value
  output count_t       o_compare_reg_b,
  output logic         o_overflow_flag,
  output logic         o_compare_flag_a,
  output logic         o_compare_flag_b,
  output logic         o_capture_top_flag, // capture_flag set at top
  output logic         o_chan_a_output_state,
  output logic         o_chan_b_output_state,
  output logic         o_pin_a_out,
  output logic         o_pin_a_oe_n,
  output logic         o_pin_b_out,
  output logic         o_pin_b_oe_n
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // registers of the counter, compare values and flags, then the
  // decoded events that drive them
  count_t cnt_q, cnt_d;
  count_t ocr_a_q, ocr_a_d, ocr_b_q, ocr_b_d;
  count_t buf_a_q, buf_a_d, buf_b_q, buf_b_d;
  logic   blk_q, blk_d;
  logic   ovf_q, ovf_d, fa_q, fa_d, fb_q, fb_d, ficap_q, ficap_d;
  seq_class_t seq;
  count_t top;
  logic   is_pwm, at_top, match_a, match_b, bottom_ev;
  logic   top_is_a, top_is_cap;
  logic   adv;                 // tick not overridden by a count write

  // ----------------------------------------------------------------
  // mode decode; action fields play no part here
  // ----------------------------------------------------------------
  // unlisted modes count like pwm to the maximum with buffered compares
  function automatic seq_class_t mode_class(input logic [3:0] m);
    case (m)
      `WGM_NORMAL:                          mode_class = SEQ_NORMAL;
      `WGM_CTC_A, `WGM_CTC_CAP:             mode_class = SEQ_CTC;
      `WGM_FPWM_8, `WGM_FPWM_9, `WGM_FPWM_10,
      `WGM_FPWM_CAP, `WGM_FPWM_A:           mode_class = SEQ_FPWM;
      default:                              mode_class = SEQ_OTHER;
    endcase
  endfunction

  // equality of the count with one compare value, dropped while blocked
  function automatic logic hit_of(input count_t c, input count_t r,
                                  input logic blk);
    hit_of = (c == r) && !blk;
  endfunction

  // top value selected by mode; software keeps a register top at three
  // or more, lower tops are not guarded here
  always_comb begin
    seq        = mode_class(i_waveform_mode_field);
    is_pwm     = (seq == SEQ_FPWM) || (seq == SEQ_OTHER);
    top_is_a   = 1'b0;
    top_is_cap = 1'b0;
    case (i_waveform_mode_field)
      // fixed tops of the 8, 9 and 10 bit fast pwm modes
      `WGM_FPWM_8:  top = `TOP_8BIT;
      `WGM_FPWM_9:  top = `TOP_9BIT;
      `WGM_FPWM_10: top = `TOP_10BIT;
      `WGM_CTC_A, `WGM_FPWM_A: begin
        top      = ocr_a_q;
        top_is_a = 1'b1;
      end
      `WGM_CTC_CAP, `WGM_FPWM_CAP: begin
        // unbuffered: a top written below the count is missed until
        // the counter wraps through zero
        top        = i_capture_reg;                 // direct
        top_is_cap = 1'b1;
      end
      default: top = `CNT_MAX;
    endcase
  end

  // match detection, blocked the timer cycle after a counter write;
  // a write in the same cycle wins over the tick, so its events drop
  always_comb begin
    adv       = i_tick && !i_count_wr;
    match_a   = hit_of(cnt_q, ocr_a_q, blk_q || i_count_wr);
    match_b   = hit_of(cnt_q, ocr_b_q, blk_q || i_count_wr);
    at_top    = (seq != SEQ_NORMAL) && hit_of(cnt_q, top, blk_q);
    bottom_ev = adv && at_top && (seq == SEQ_FPWM);
  end

  // ----------------------------------------------------------------
  // counter and write blocking
  // ----------------------------------------------------------------
  // a write wins over a tick in the same cycle; writing the count equal
  // to a variable top loses that top, so the count runs on to maximum
  always_comb begin
    cnt_d = cnt_q;
    blk_d = blk_q;
    // the block lasts until the next tick, even while the timer stops
    if (i_tick)
      blk_d = 1'b0;
    if (i_count_wr) begin
      cnt_d = i_count_wdata;                        // any time
      blk_d = 1'b1;
    end else if (i_tick) begin
      if (at_top)
        cnt_d = `CNT_BOTTOM;
      else
        cnt_d = cnt_q + 16'h0001;                   // wraps
    end
  end

  // counter and block registers
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cnt_q <= `CNT_RESET;
      blk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      blk_q <= blk_d;
    end
  end

  // ----------------------------------------------------------------
  // compare registers: direct in non-pwm, buffered to top in pwm
  // ----------------------------------------------------------------
  // writes land in the buffer at all times; the active value takes the
  // write directly in non-pwm modes and the buffer at top in pwm modes
  always_comb begin
    ocr_a_d = ocr_a_q;
    ocr_b_d = ocr_b_q;
    buf_a_d = i_cmp_a_wr ? i_cmp_wdata : buf_a_q;
    buf_b_d = i_cmp_b_wr ? i_cmp_wdata : buf_b_q;
    if (!is_pwm) begin
      if (i_cmp_a_wr)
        ocr_a_d = i_cmp_wdata;
      if (i_cmp_b_wr)
        ocr_b_d = i_cmp_wdata;
    end else if (adv && at_top) begin
      // same cycle as the counter clears and, in fast pwm modes only, the overflow flag sets
      ocr_a_d = buf_a_q;
      ocr_b_d = buf_b_q;
    end
  end

  // active and buffer compare registers
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ocr_a_q <= `CNT_RESET;
      ocr_b_q <= `CNT_RESET;
      buf_a_q <= `CNT_RESET;
      buf_b_q <= `CNT_RESET;
    end else begin
      ocr_a_q <= ocr_a_d;
      ocr_b_q <= ocr_b_d;
      buf_a_q <= buf_a_d;
      buf_b_q <= buf_b_d;
    end
  end

  // ----------------------------------------------------------------
  // flags: set wins over clear
  // ----------------------------------------------------------------
  // each flag is a sticky level: its clear pulse drops it at the next
  // edge unless its event lands in the same cycle
  always_comb begin
    ovf_d   = ovf_q   && !i_ovf_clr;
    fa_d    = fa_q    && !i_flag_a_clr;
    fb_d    = fb_q    && !i_flag_b_clr;
    // the capture top flag shares the channel a clear pulse
    ficap_d = ficap_q && !i_flag_a_clr;
    if (adv) begin
      // fast pwm overflow at top with the top flag; otherwise as the
      // count passes maximum to zero other than by clearing at top, like a seventeenth
      // count bit, so in unlisted modes, whose top is the maximum, only after the count is written to maximum
      if (seq == SEQ_FPWM && at_top)
        ovf_d = 1'b1;
      else if (seq != SEQ_FPWM && cnt_q == `CNT_MAX && !at_top)
        ovf_d = 1'b1;
      if (match_a)
        fa_d = 1'b1;
      if (match_b)
        fb_d = 1'b1;
      if (at_top && top_is_cap)
        ficap_d = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ovf_q   <= 1'b0;
      fa_q    <= 1'b0;
      fb_q    <= 1'b0;
      ficap_q <= 1'b0;
    end else begin
      ovf_q   <= ovf_d;
      fa_q    <= fa_d;
      fb_q    <= fb_d;
      ficap_q <= ficap_d;
    end
  end

  // registered state straight to the ports
  assign o_count_value      = cnt_q;
  assign o_compare_reg_a    = ocr_a_q;
  assign o_compare_reg_b    = ocr_b_q;
  assign o_overflow_flag    = ovf_q;
  assign o_compare_flag_a   = fa_q;
  assign o_compare_flag_b   = fb_q;
  assign o_capture_top_flag = ficap_q;

  // ----------------------------------------------------------------
  // output channels; capture path untouched by action fields
  // ----------------------------------------------------------------
  // both channels share the counter, the top and the bottom event; only
  // compare value, action, force strobe and pin differ. channel a toggle in mode 4 gives
  // half the timer clock with compare zero
  compare_output_unit u_chan_a (                    // toggle
    .i_core_clk      (i_core_clk),
    .i_resetn        (i_resetn),
    .i_tick          (i_tick),
    .i_is_pwm        (is_pwm),
    .i_action        (i_chan_a_output_action),
    .i_match         (match_a),
    .i_bottom        (bottom_ev),
    .i_force         (i_force_a),
    .i_port_data     (i_port_data_a),
    .i_pin_direction (i_chan_a_pin_direction),
    .o_state         (o_chan_a_output_state),
    .o_pin_out       (o_pin_a_out),
    .o_pin_oe_n      (o_pin_a_oe_n)
  );

  // channel b plays no part in setting top
  compare_output_unit u_chan_b (
    .i_core_clk      (i_core_clk),
    .i_resetn        (i_resetn),
    .i_tick          (i_tick),
    .i_is_pwm        (is_pwm),
    .i_action        (i_chan_b_output_action),
    .i_match         (match_b),
    .i_bottom        (bottom_ev),
    .i_force         (i_force_b),
    .i_port_data     (i_port_data_b),
    .i_pin_direction (i_chan_b_pin_direction),
    .o_state         (o_chan_b_output_state),
    .o_pin_out       (o_pin_b_out),
    .o_pin_oe_n      (o_pin_b_oe_n)
  );
endmodule
